// >>> dv/pwsc_props.sv
// Purpose: Port assertions for the power standby control block
// Assumes: One clock, synchronous active-low reset
// Notes: lows mirrors the two-sample request filter from the pins
module pwsc_props import pwsc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [PWSC_ADDR_W-1:0] i_addr,
  input wire logic [PWSC_DATA_W-1:0] i_wdata,
  input wire logic i_we,
  input wire logic i_hw_standby_request_pin_n,
  input wire logic i_power_on_reset_pin_n,
  input wire logic i_calendar_crystal_input,
  input wire logic i_manual_reset_req,
  input wire logic i_sleep_mode,
  input wire logic i_watchdog_settling,
  input wire logic o_timer_clk_en,
  input wire logic o_cal_if_clk_en,
  input wire logic o_cal_access_block,
  input wire logic o_serial_clk_en,
  input wire logic o_hw_standby,
  input wire logic o_sysclk_hold_stop,
  input wire logic o_osc_enable,
  input wire logic o_resume_req,
  input wire logic o_por_start,
  input wire logic o_irq_accept_en,
  input wire logic o_manual_reset,
  input wire logic o_timer_clock_output_low
);
  logic cal_q;
  logic [1:0] lows;
  wire cal_rise = i_calendar_crystal_input && !cal_q;
  wire req_lo = !i_hw_standby_request_pin_n;
  wire busy = i_sleep_mode || i_watchdog_settling;
  always_ff @(posedge i_clk) begin
    // Power-on reset empties the filter as well
    cal_q <= i_resetn && i_power_on_reset_pin_n && i_calendar_crystal_input;
    if (!i_resetn || !i_power_on_reset_pin_n || (cal_rise && !req_lo)) lows <= 2'h0;
    else if (cal_rise && lows != 2'h2) lows <= lows + 2'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_por_exit;
    o_por_start ##1 (!o_por_start && !o_hw_standby);
  endsequence
  // Writes that race a standby entry or a clear are left out
  sequence s_wr_stop;
    i_we && i_addr == PWSC_OFF_MODSTOP && !o_hw_standby && !o_resume_req && i_power_on_reset_pin_n
      && !i_manual_reset_req && lows != 2'h2;
  endsequence
  stop_write_a: assert property (s_wr_stop |=>
    o_timer_clk_en == !$past(i_wdata[PWSC_BIT_TIMER]) && o_cal_if_clk_en == !$past(i_wdata[PWSC_BIT_CAL])
    && o_serial_clk_en == !$past(i_wdata[PWSC_BIT_SERIAL])) else $error("stop write not applied");
  stop_clear_a: assert property ((!i_power_on_reset_pin_n || i_manual_reset_req && !o_hw_standby) |->
    ##[1:2] !o_cal_access_block) else $error("stops not cleared");
  stby_gate_a: assert property (o_hw_standby && !o_por_start |->
    !o_timer_clk_en && !o_serial_clk_en && !o_irq_accept_en && !o_manual_reset) else $error("unit runs in standby");
  timer_clock_output_low_a: assert property (o_hw_standby |-> o_timer_clock_output_low && o_sysclk_hold_stop)
    else $error("clock not held in standby");
  stby_hold_a: assert property (o_hw_standby && !(o_osc_enable && i_power_on_reset_pin_n) |=> o_hw_standby)
    else $error("standby left");
  osc_start_a: assert property (o_hw_standby && !o_osc_enable && !req_lo && !i_power_on_reset_pin_n
    |=> o_osc_enable) else $error("oscillator not restarted");
  por_exit_a: assert property (o_hw_standby && o_osc_enable && !o_por_start && i_power_on_reset_pin_n
    |=> s_por_exit) else $error("no power-on reset start");
  stby_entry_a: assert property (lows == 2'h2 && req_lo |-> ##[0:3] (o_hw_standby || o_resume_req))
    else $error("accepted request ignored");
  filt_guard_a: assert property (!o_hw_standby && !o_resume_req && lows != 2'h2
    |=> !o_hw_standby && !o_resume_req) else $error("request taken early");
  wake_hold_a: assert property (o_resume_req && busy |=> !o_hw_standby) else $error("standby too soon");
  wake_go_a: assert property (o_resume_req && !busy |=> o_hw_standby) else $error("standby missed");
endmodule
bind pwsc_top pwsc_props u_props (.*);

// >>> dv/pwsc_pwr_model.sv
// Purpose: Board power manager: standby request, power-on reset, calendar clock
// Assumes: Calendar clock divided from the 25 MHz bench clock
// Notes: 381 cycles a half period is the nearest to 32.768 kHz
module pwsc_pwr_model (
  input wire logic i_clk,
  output logic o_req_n = 1'b1,
  output logic o_por_n = 1'b1,
  output logic o_cal = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge i_clk) begin
    cnt <= (cnt == 380) ? 0 : cnt + 1;
    if (cnt == 380) o_cal <= ~o_cal;
  end
  // No interrupt or manual reset line comes from here while in standby
  // Margin after each edge so the pin never moves at a sample
  task automatic rises(input int n);
    repeat (n) @(posedge o_cal);
    repeat (4) @(posedge i_clk);
  endtask
  task automatic request();
    o_req_n <= 1'b0;
    rises(3);
  endtask
  task automatic glitch();
    o_req_n <= 1'b0;
    rises(1);
    o_req_n <= 1'b1;
    rises(1);
    o_req_n <= 1'b0;
    rises(1);
    o_req_n <= 1'b1;
    rises(1);
  endtask
  task automatic osc_start();
    o_por_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_req_n <= 1'b1;
  endtask
  task automatic por_release(input int settle);
    repeat (settle) @(posedge i_clk);
    o_por_n <= 1'b1;
  endtask
endmodule

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the power standby control block
// Assumes: Power model drives request, power-on reset and calendar pins
// Notes: Each standby entry waits three calendar edges, most of the run time
module testbench import pwsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_we = 1'b0, i_re = 1'b0, i_manual_reset_req = 1'b0;
  logic i_sleep_mode = 1'b0, i_sw_standby_mode = 1'b0, i_watchdog_settling = 1'b0;
  logic [PWSC_ADDR_W-1:0] i_addr = 4'h0;
  logic [PWSC_DATA_W-1:0] i_wdata = 8'h00, o_rdata, d;
  logic i_hw_standby_request_pin_n, i_power_on_reset_pin_n, i_calendar_crystal_input, seen;
  logic o_timer_clk_en, o_timer_regs_init, o_cal_if_clk_en, o_cal_access_block, o_serial_clk_en, o_hw_standby;
  logic o_sysclk_hold_stop, o_osc_enable, o_resume_req, o_por_start, o_irq_accept_en, o_manual_reset;
  logic o_timer_clock_output_low;
  int error_cnt = 0, n_checks = 0;
  wire [4:0] gates = {o_timer_clk_en, o_timer_regs_init, o_cal_if_clk_en, o_cal_access_block, o_serial_clk_en};
  pwsc_top dut (.*);
  pwsc_pwr_model pm (.i_clk(i_clk), .o_req_n(i_hw_standby_request_pin_n), .o_por_n(i_power_on_reset_pin_n),
    .o_cal(i_calendar_crystal_input));
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic mreset();
    @(posedge i_clk);
    i_manual_reset_req <= 1'b1;
    @(posedge i_clk);
    i_manual_reset_req <= 1'b0;
    #1;
  endtask
  task automatic t_regs();
    logic [14:0] tbl;
    tbl = 15'h526d;
    for (int b = 0; b < 3; b++) begin
      wr(PWSC_OFF_MODSTOP, 8'hf8 | (8'h01 << b));
      chk({3'h0, gates}, {3'h0, tbl[b*5 +: 5]}, "unit gates");
      rd(PWSC_OFF_MODSTOP);
      chk(d, 8'h01 << b, "stop readback");
    end
    wr(PWSC_OFF_MODSTOP, 8'h00);
    chk({3'h0, gates}, 8'h15, "release");
    wr(4'h8, 8'hff);
    rd(4'h8);
    chk(d, 8'h00, "unmapped");
    wr(PWSC_OFF_MODSTOP, 8'h07);
    rd(PWSC_OFF_MODSTOP);
    chk(d, 8'h07, "all stopped");
    mreset();
    chk(o_manual_reset, 1'b1, "manual taken");
    rd(PWSC_OFF_MODSTOP);
    chk(d, 8'h00, "manual clear");
  endtask
  // Mode 0 normal, 1 sleep, 2 watchdog settling, 3 software standby
  task automatic t_stby(input int mode);
    @(posedge i_clk);
    i_sleep_mode <= (mode == 1);
    i_watchdog_settling <= (mode == 2);
    i_sw_standby_mode <= (mode == 3);
    wr(PWSC_OFF_MODSTOP, 8'h04);
    pm.request();
    #1;
    if (mode == 1 || mode == 2) begin
      chk({o_resume_req, o_hw_standby}, 8'h2, "resume first");
      @(posedge i_clk);
      i_sleep_mode <= 1'b0;
      i_watchdog_settling <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
    end
    chk({o_hw_standby, o_osc_enable, o_irq_accept_en, o_timer_clk_en}, 8'h8, "standby");
    chk({o_sysclk_hold_stop, o_timer_clock_output_low}, 8'h3, "clock held");
    rd(PWSC_OFF_STATUS);
    chk(d, (mode == 3) ? 8'hb3 : 8'h33, "status word");
    mreset();
    chk(o_manual_reset, 1'b0, "manual ignored");
    wr(PWSC_OFF_MODSTOP, 8'h00);
    chk({o_timer_clk_en, o_hw_standby}, 8'h1, "timer halted");
    @(posedge i_clk);
    i_sw_standby_mode <= 1'b0;
    pm.osc_start();
    repeat (2) @(posedge i_clk);
    #1;
    chk({o_osc_enable, o_hw_standby}, 8'h3, "oscillator");
    pm.por_release(16);
    seen = 1'b0;
    for (int i = 0; i < 8 && seen !== 1'b1; i++) begin
      @(posedge i_clk);
      #1;
      seen = o_por_start;
    end
    chk(seen, 1'b1, "por start");
    @(posedge i_clk);
    #1;
    chk({o_hw_standby, o_serial_clk_en}, 8'h1, "normal again");
  endtask
  initial forever #20 i_clk = ~i_clk;
  initial begin
    repeat (100000) @(posedge i_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_regs();
    pm.glitch();
    chk({o_hw_standby, o_resume_req}, 8'h0, "filter restart");
    for (int m = 0; m < 4; m++) t_stby(m);
    test_done();
  end
endmodule

// >>> rtl/pwsc_filter.sv
// Purpose: Two-sample low filter for the hardware standby request pin
// Assumes: Calendar crystal input is a slow level sampled on the fast clock
// Notes: Samples are taken on each rising edge of the calendar input
module pwsc_filter import pwsc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_calendar_crystal,
  input wire logic i_req_pin_n,
  output logic o_accepted
);

  logic cal_prev_r;
  logic [1:0] low_cnt_r;
  logic [1:0] low_cnt_nxt;
  logic cal_rise;

  assign cal_rise = i_calendar_crystal & ~cal_prev_r;

  // Saturate at two; any high sample restarts the count
  assign low_cnt_nxt = !cal_rise ? low_cnt_r :
                       i_req_pin_n ? PWSC_FILT_RST :
                       (low_cnt_r == PWSC_FILT_LOWS) ? low_cnt_r :
                       low_cnt_r + 2'h1;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cal_prev_r <= 1'b0;
      low_cnt_r <= PWSC_FILT_RST;
    end else begin
      cal_prev_r <= i_calendar_crystal;
      low_cnt_r <= low_cnt_nxt;
    end
  end

  assign o_accepted = (low_cnt_r == PWSC_FILT_LOWS);

endmodule

// >>> rtl/pwsc_pkg.sv
// Purpose: Constants and types for the power standby control block
// Assumes: One 25 MHz clock; all pins already synchronous to it
// Notes: Register offsets are byte addresses on the plain register port
package pwsc_pkg;

  localparam int PWSC_ADDR_W = 4;
  localparam int PWSC_DATA_W = 8;

  localparam logic [PWSC_ADDR_W-1:0] PWSC_OFF_MODSTOP = 4'h0;
  localparam logic [PWSC_ADDR_W-1:0] PWSC_OFF_STATUS = 4'h4;

  localparam int PWSC_BIT_TIMER = 0;
  localparam int PWSC_BIT_CAL = 1;
  localparam int PWSC_BIT_SERIAL = 2;
  localparam int PWSC_STOP_W = 3;
  localparam logic [PWSC_STOP_W-1:0] PWSC_STOP_RST = 3'h0;

  localparam int PWSC_ST_HWSTBY = 0;
  localparam int PWSC_ST_ACCEPT = 1;
  localparam int PWSC_ST_WAKE = 2;
  localparam int PWSC_ST_OSC = 3;
  localparam int PWSC_ST_FSM_LO = 4;
  localparam int PWSC_ST_FSM_HI = 6;

  localparam logic [1:0] PWSC_FILT_LOWS = 2'h2;
  localparam logic [1:0] PWSC_FILT_RST = 2'h0;

  typedef enum logic [2:0] {
    PWSC_NORMAL = 3'h0,
    PWSC_WAKE = 3'h1,
    PWSC_HWSTBY = 3'h3,
    PWSC_OSC = 3'h2,
    PWSC_POR = 3'h6
  } pwsc_state_e;

  typedef struct packed {
    logic serial;
    logic cal;
    logic timer;
  } pwsc_stop_s;

  typedef struct packed {
    logic timer_clk_en;
    logic timer_regs_init;
    logic cal_if_clk_en;
    logic cal_access_block;
    logic serial_clk_en;
  } pwsc_clk_ctl_s;

endpackage

// >>> rtl/pwsc_top.sv
// Purpose: Module stop controls and hardware standby sequencing
// Assumes: i_clk keeps running in hardware standby, fed from the always-on domain
// Notes: Processor, watchdog and sleep logic sit outside and report their state here
module pwsc_top import pwsc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [PWSC_ADDR_W-1:0] i_addr,
  input wire logic [PWSC_DATA_W-1:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [PWSC_DATA_W-1:0] o_rdata,
  input wire logic i_hw_standby_request_pin_n,
  input wire logic i_power_on_reset_pin_n,
  input wire logic i_calendar_crystal_input,
  input wire logic i_manual_reset_req,
  input wire logic i_sleep_mode,
  input wire logic i_sw_standby_mode,
  input wire logic i_watchdog_settling,
  output logic o_timer_clk_en,
  output logic o_timer_regs_init,
  output logic o_cal_if_clk_en,
  output logic o_cal_access_block,
  output logic o_serial_clk_en,
  output logic o_hw_standby,
  output logic o_sysclk_hold_stop,
  output logic o_osc_enable,
  output logic o_resume_req,
  output logic o_por_start,
  output logic o_irq_accept_en,
  output logic o_manual_reset,
  output logic o_timer_clock_output_low
);

  function automatic logic addr_hit(
    input logic [PWSC_ADDR_W-1:0] addr,
    input logic [PWSC_ADDR_W-1:0] off
  );
    addr_hit = (addr == off);
  endfunction

  // Standby covers the oscillator restart phase as well
  function automatic logic in_stby_state(input pwsc_state_e s);
    in_stby_state = (s == PWSC_HWSTBY) || (s == PWSC_OSC);
  endfunction

  pwsc_state_e state_r;
  pwsc_state_e state_nxt;
  pwsc_stop_s stop_r;
  pwsc_stop_s stop_nxt;
  pwsc_clk_ctl_s clk_ctl_r;
  pwsc_clk_ctl_s clk_ctl_nxt;
  logic [PWSC_DATA_W-1:0] rdata_r;
  logic [PWSC_DATA_W-1:0] rdata_nxt;
  logic [PWSC_DATA_W-1:0] status_word;
  logic [PWSC_DATA_W-1:0] stop_word;
  logic req_accepted;
  logic from_sw_standby_r;
  logic from_sw_standby_nxt;
  logic in_standby;
  logic wake_busy;
  logic wr_stop;
  logic rd_stop;
  logic rd_status;
  logic mrst_take;
  logic clear_all;
  logic hw_standby_r;
  logic sysclk_hold_r;
  logic osc_en_r;
  logic resume_r;
  logic por_start_r;
  logic irq_en_r;
  logic mrst_r;
  logic timer_clock_output_low_r;
  logic stby_nxt;
  logic [PWSC_STOP_W-1:0] unit_run;
  logic filt_resetn;
  logic hw_standby_nxt;
  logic sysclk_hold_nxt;
  logic osc_en_nxt;
  logic resume_nxt;
  logic por_start_nxt;
  logic irq_en_nxt;
  logic mrst_nxt;
  logic timer_clock_output_low_nxt;

  // A power-on reset also empties the filter, or a stale count would re-enter standby at once
  assign filt_resetn = i_resetn && i_power_on_reset_pin_n;

  pwsc_filter u_filter (
    .i_clk(i_clk),
    .i_resetn(filt_resetn),
    .i_calendar_crystal(i_calendar_crystal_input),
    .i_req_pin_n(i_hw_standby_request_pin_n),
    .o_accepted(req_accepted)
  );

  // Standby covers the oscillator restart phase too; nothing wakes the core there
  assign in_standby = in_stby_state(state_r);

  // Low-power exits still in progress must finish before standby is entered
  assign wake_busy = i_sleep_mode | i_watchdog_settling;

  // Register decode
  assign wr_stop = i_we && addr_hit(i_addr, PWSC_OFF_MODSTOP) && !in_standby;
  assign rd_stop = i_re && addr_hit(i_addr, PWSC_OFF_MODSTOP);
  assign rd_status = i_re && addr_hit(i_addr, PWSC_OFF_STATUS);

  // Manual reset is dropped while standby holds the chip
  assign mrst_take = i_manual_reset_req && !in_standby;

  // Either reset source releases every module stop
  assign clear_all = !i_power_on_reset_pin_n || mrst_take;

  // Module stop bits: reset beats software write
  always_comb begin
    stop_nxt = stop_r;
    if (wr_stop) begin
      stop_nxt.timer = i_wdata[PWSC_BIT_TIMER];
      stop_nxt.cal = i_wdata[PWSC_BIT_CAL];
      stop_nxt.serial = i_wdata[PWSC_BIT_SERIAL];
    end
    if (clear_all) begin
      stop_nxt = pwsc_stop_s'(PWSC_STOP_RST);
    end
  end

  // Standby sequencer
  always_comb begin
    state_nxt = state_r;
    from_sw_standby_nxt = from_sw_standby_r;
    unique case (state_r)
      PWSC_NORMAL: begin
        if (req_accepted) begin
          if (wake_busy) begin
            state_nxt = PWSC_WAKE;
          end else begin
            state_nxt = PWSC_HWSTBY;
            from_sw_standby_nxt = i_sw_standby_mode;
          end
        end
      end
      PWSC_WAKE: begin
        // Hold off until the processor has really resumed
        if (!wake_busy) begin
          state_nxt = PWSC_HWSTBY;
          from_sw_standby_nxt = 1'b0;
        end
      end
      PWSC_HWSTBY: begin
        // Only the power-on reset path leads out of here
        if (i_hw_standby_request_pin_n && !i_power_on_reset_pin_n) begin
          state_nxt = PWSC_OSC;
        end
      end
      PWSC_OSC: begin
        // The outside controller times the settling by holding reset low
        if (i_power_on_reset_pin_n) begin
          state_nxt = PWSC_POR;
        end else if (!i_hw_standby_request_pin_n) begin
          state_nxt = PWSC_HWSTBY;
        end
      end
      PWSC_POR: begin
        state_nxt = PWSC_NORMAL;
        from_sw_standby_nxt = 1'b0;
      end
      default: begin
        state_nxt = PWSC_NORMAL;
        from_sw_standby_nxt = 1'b0;
      end
    endcase
  end

  // Clock controls; timer is held off in standby whatever its bit says
  assign stby_nxt = in_stby_state(state_nxt);

  // One run enable per unit: its stop bit clear and the chip out of standby
  for (genvar g = 0; g < PWSC_STOP_W; g++) begin : g_unit_run
    assign unit_run[g] = !stop_nxt[g] && !stby_nxt;
  end

  always_comb begin
    clk_ctl_nxt.timer_clk_en = unit_run[PWSC_BIT_TIMER];
    clk_ctl_nxt.timer_regs_init = stop_nxt.timer || stby_nxt;
    clk_ctl_nxt.cal_if_clk_en = unit_run[PWSC_BIT_CAL];
    clk_ctl_nxt.cal_access_block = stop_nxt.cal;
    clk_ctl_nxt.serial_clk_en = unit_run[PWSC_BIT_SERIAL];
  end

  // Status word for software; the top bit records an entry made from software standby
  assign status_word = {
    from_sw_standby_r,
    state_r,
    (state_r == PWSC_OSC),
    (state_r == PWSC_WAKE),
    req_accepted,
    in_standby
  };

  assign stop_word = {{(PWSC_DATA_W-PWSC_STOP_W){1'b0}}, stop_r};

  // Read data lives for exactly the cycle after the strobe
  assign rdata_nxt = rd_stop ? stop_word :
                     rd_status ? status_word :
                     {PWSC_DATA_W{1'b0}};

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_r <= PWSC_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      from_sw_standby_r <= 1'b0;
    end else begin
      from_sw_standby_r <= from_sw_standby_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      stop_r <= pwsc_stop_s'(PWSC_STOP_RST);
    end else begin
      stop_r <= stop_nxt;
    end
  end

  // Enables come up running so no unit sits frozen after reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      clk_ctl_r <= '{
        timer_clk_en: 1'b1,
        timer_regs_init: 1'b0,
        cal_if_clk_en: 1'b1,
        cal_access_block: 1'b0,
        serial_clk_en: 1'b1
      };
    end else begin
      clk_ctl_r <= clk_ctl_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_r <= {PWSC_DATA_W{1'b0}};
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Pin-facing and sequencing outputs, all from next state so they change with it
  assign hw_standby_nxt = stby_nxt;
  assign sysclk_hold_nxt = stby_nxt;
  assign osc_en_nxt = (state_nxt != PWSC_HWSTBY);
  assign resume_nxt = (state_nxt == PWSC_WAKE);
  assign por_start_nxt = (state_nxt == PWSC_POR);
  assign irq_en_nxt = !stby_nxt;
  // A request on the entry edge still clears the stops but gives no pulse, so the output never pulses inside standby
  assign mrst_nxt = mrst_take && !stby_nxt;
  assign timer_clock_output_low_nxt = stby_nxt;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hw_standby_r <= 1'b0;
    end else begin
      hw_standby_r <= hw_standby_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sysclk_hold_r <= 1'b0;
    end else begin
      sysclk_hold_r <= sysclk_hold_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      osc_en_r <= 1'b1;
    end else begin
      osc_en_r <= osc_en_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      resume_r <= 1'b0;
    end else begin
      resume_r <= resume_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      por_start_r <= 1'b0;
    end else begin
      por_start_r <= por_start_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      irq_en_r <= 1'b1;
    end else begin
      irq_en_r <= irq_en_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      mrst_r <= 1'b0;
    end else begin
      mrst_r <= mrst_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      timer_clock_output_low_r <= 1'b0;
    end else begin
      timer_clock_output_low_r <= timer_clock_output_low_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_timer_clk_en = clk_ctl_r.timer_clk_en;
  assign o_timer_regs_init = clk_ctl_r.timer_regs_init;
  assign o_cal_if_clk_en = clk_ctl_r.cal_if_clk_en;
  assign o_cal_access_block = clk_ctl_r.cal_access_block;
  assign o_serial_clk_en = clk_ctl_r.serial_clk_en;
  assign o_hw_standby = hw_standby_r;
  assign o_sysclk_hold_stop = sysclk_hold_r;
  assign o_osc_enable = osc_en_r;
  assign o_resume_req = resume_r;
  assign o_por_start = por_start_r;
  assign o_irq_accept_en = irq_en_r;
  assign o_manual_reset = mrst_r;
  assign o_timer_clock_output_low = timer_clock_output_low_r;

endmodule
